/* File: pso_pkg.sv */
package pso_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [9:0] ADDR_STATUS = 10'h01F;
  localparam logic [9:0] ADDR_DRV_CTRL = 10'h0F0;

  // ************************************************************
  // Status byte field positions
  // ************************************************************
  localparam int ST_HOLDOVER = 5;
  localparam int ST_SEC_SEL = 4;
  localparam int ST_VCO_OK = 3;
  localparam int ST_SEC_OK = 2;
  localparam int ST_PRI_OK = 1;
  localparam int ST_LOCK = 0;
  localparam logic [7:0] ST_RESERVED_VAL = 8'h00;
  localparam logic [7:0] RD_UNMAPPED_VAL = 8'h00;

  // ************************************************************
  // Output control field positions and reset value
  // ************************************************************
  localparam int OC_FORMAT = 7;
  localparam int OC_CMOS_HI = 6;
  localparam int OC_CMOS_LO = 5;
  localparam int OC_POL_HI = 4;
  localparam int OC_POL_LO = 3;
  localparam int OC_LVL_HI = 2;
  localparam int OC_LVL_LO = 1;
  localparam int OC_PDN = 0;
  localparam logic [7:0] OC_RESET_VAL = 8'h62;
  localparam logic [1:0] CMOS_BOTH_OFF = 2'h0;
  localparam logic [1:0] CMOS_A_ONLY = 2'h1;
  localparam logic [1:0] CMOS_B_ONLY = 2'h2;
  localparam logic [1:0] CMOS_BOTH_ON = 2'h3;

  typedef struct packed {
    logic holdover_active;
    logic secondary_selected;
    logic vco_above;
    logic secondary_above;
    logic primary_above;
    logic digital_lock;
  } pso_monitor_type;

  typedef struct packed {
    logic cmos_mode;
    logic half_a_en;
    logic half_b_en;
    logic pol_a_inv;
    logic pol_b_inv;
    logic [1:0] lvds_level;
    logic powered_down;
  } pso_drive_type;

endpackage

/* File: pso_sync.sv */
`timescale 1ns/1ps
module pso_sync #(
  parameter int WIDTH = 6
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= d_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign q_o = stage2_reg;

endmodule

/* File: pso_regs.sv */
`timescale 1ns/1ps
module pso_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [9:0] addr_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire pso_pkg::pso_monitor_type monitor_i,
  output pso_pkg::pso_drive_type drive_o
);
  import pso_pkg::*;

  // ************************************************************
  // Monitor inputs
  // ************************************************************
  // Monitors live in other clock domains, so each bit is synchronised.
  pso_monitor_type mon_sync;

  pso_sync #(
    .WIDTH($bits(pso_monitor_type))
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(monitor_i),
    .q_o(mon_sync)
  );

  // ************************************************************
  // Status byte
  // ************************************************************
  logic [7:0] status_byte;

  always_comb begin
    status_byte = ST_RESERVED_VAL;
    status_byte[ST_HOLDOVER] = mon_sync.holdover_active;
    status_byte[ST_SEC_SEL] = mon_sync.secondary_selected;
    status_byte[ST_VCO_OK] = mon_sync.vco_above;
    status_byte[ST_SEC_OK] = mon_sync.secondary_above;
    status_byte[ST_PRI_OK] = mon_sync.primary_above;
    status_byte[ST_LOCK] = mon_sync.digital_lock;
  end

  // ************************************************************
  // Driver decode
  // ************************************************************
  // One decode serves both the reset image and the next value, so they cannot drift apart.
  function automatic pso_drive_type drive_decode(input logic [7:0] ctrl);
    pso_drive_type d;
    logic fmt;
    logic off;
    logic [1:0] cfg;
    fmt = ctrl[OC_FORMAT];
    off = ctrl[OC_PDN];
    cfg = ctrl[OC_CMOS_HI:OC_CMOS_LO];
    d.cmos_mode = fmt;
    // Power-down wins over the half gating, so a tristated driver never shows as enabled.
    d.half_a_en = ~off & (~fmt | cfg[0]);
    d.half_b_en = ~off & (~fmt | cfg[1]);
    // Half B in CMOS mode inverts when the two polarity bits differ.
    d.pol_a_inv = ctrl[OC_POL_LO];
    d.pol_b_inv = fmt ? (ctrl[OC_POL_HI] ^ ctrl[OC_POL_LO]) : ~ctrl[OC_POL_LO];
    d.lvds_level = ctrl[OC_LVL_HI:OC_LVL_LO];
    d.powered_down = off;
    return d;
  endfunction

  localparam pso_drive_type DRV_RESET = drive_decode(OC_RESET_VAL);

  // ************************************************************
  // Output control byte
  // ************************************************************
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  pso_drive_type drive_reg;
  pso_drive_type drive_next;
  wire hit_ctrl = (addr_i == ADDR_DRV_CTRL);
  wire hit_status = (addr_i == ADDR_STATUS);

  // Writes to the status address fall through and change nothing.
  assign ctrl_next = (wr_i && hit_ctrl) ? wdata_i : ctrl_reg;
  assign drive_next = drive_decode(ctrl_next);
  assign rdata_next = hit_ctrl ? ctrl_reg : (hit_status ? status_byte : RD_UNMAPPED_VAL);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= OC_RESET_VAL;
      drive_reg <= DRV_RESET;
      rdata_reg <= RD_UNMAPPED_VAL;
    end else begin
      ctrl_reg <= ctrl_next;
      drive_reg <= drive_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
  // The pins are fed from flip-flops so decode glitches never reach the output stage.
  assign drive_o = drive_reg;

  // ************************************************************
  // Control fields seen by the checks
  // ************************************************************
  wire fmt_cmos = ctrl_reg[OC_FORMAT];
  wire [1:0] cmos_cfg = ctrl_reg[OC_CMOS_HI:OC_CMOS_LO];
  wire pol_hi = ctrl_reg[OC_POL_HI];
  wire pol_lo = ctrl_reg[OC_POL_LO];
  wire pdn = ctrl_reg[OC_PDN];

  // ************************************************************
  // Checks
  // ************************************************************
  // Each monitor bit takes two clocks through the synchroniser, hence the two-cycle offset.
  a_status_lock: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(monitor_i.digital_lock) |-> ##2 status_byte[ST_LOCK])
    else $error("Lock bit did not follow the detector.");
  a_lock_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##2 (status_byte[ST_LOCK] == $past(monitor_i.digital_lock, 2)))
    else $error("Lock bit mismatch.");
  a_status_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##2 (status_byte[ST_HOLDOVER] == $past(monitor_i.holdover_active, 2)))
    else $error("Holdover bit mismatch.");
  a_status_select: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##2 (status_byte[ST_SEC_SEL] == $past(monitor_i.secondary_selected, 2)))
    else $error("Reference select bit mismatch.");
  a_status_vco: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##2 (status_byte[ST_VCO_OK] == $past(monitor_i.vco_above, 2)))
    else $error("VCO bit mismatch.");
  a_status_sec: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##2 (status_byte[ST_SEC_OK] == $past(monitor_i.secondary_above, 2)))
    else $error("Secondary threshold bit mismatch.");
  a_status_pri: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##2 (status_byte[ST_PRI_OK] == $past(monitor_i.primary_above, 2)))
    else $error("Primary threshold bit mismatch.");
  a_status_ro: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && hit_status) |=> $stable(ctrl_reg))
    else $error("Status write disturbed control.");
  a_ctrl_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_i && hit_ctrl) |=> $stable(ctrl_reg))
    else $error("Control changed without a write.");

  // ************************************************************
  // Control checks
  // ************************************************************
  a_format_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && hit_ctrl) |=> (drive_o.cmos_mode == $past(wdata_i[OC_FORMAT])))
    else $error("Format bit not taken.");
  a_write_pdn: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && hit_ctrl) |=> (drive_o.powered_down == $past(wdata_i[OC_PDN])))
    else $error("Power-down bit not taken.");
  a_drive_match: assert property (@(posedge mclk_i) disable iff (rst_i)
    (drive_o.cmos_mode == fmt_cmos) && (drive_o.powered_down == pdn))
    else $error("Driver state differs from control byte.");
  a_lvds_halves: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!fmt_cmos && !pdn) |-> (drive_o.half_a_en && drive_o.half_b_en))
    else $error("LVDS driver not fully enabled.");
  a_cmos_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fmt_cmos && !pdn && cmos_cfg == CMOS_A_ONLY)
    |-> (drive_o.half_a_en && !drive_o.half_b_en))
    else $error("CMOS half gating wrong.");
  a_cmos_b_only: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fmt_cmos && !pdn && cmos_cfg == CMOS_B_ONLY)
    |-> (!drive_o.half_a_en && drive_o.half_b_en))
    else $error("CMOS half B gating wrong.");
  a_cmos_both_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fmt_cmos && cmos_cfg == CMOS_BOTH_OFF) |-> !(drive_o.half_a_en || drive_o.half_b_en))
    else $error("CMOS halves not tristated.");
  a_cmos_both_on: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fmt_cmos && !pdn && cmos_cfg == CMOS_BOTH_ON) |-> (drive_o.half_a_en && drive_o.half_b_en))
    else $error("CMOS halves not both on.");
  a_pdn_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    pdn |-> !(drive_o.half_a_en || drive_o.half_b_en))
    else $error("Powered-down channel still drives.");
  a_pol_lvds: assert property (@(posedge mclk_i) disable iff (rst_i)
    !fmt_cmos |-> (drive_o.pol_a_inv != drive_o.pol_b_inv))
    else $error("LVDS legs not complementary.");
  a_pol_lvds_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !fmt_cmos |-> (drive_o.pol_a_inv == pol_lo))
    else $error("LVDS polarity of half A wrong.");
  a_pol_cmos_same: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fmt_cmos && !pol_hi) |-> (drive_o.pol_a_inv == drive_o.pol_b_inv))
    else $error("CMOS halves should share polarity.");
  a_pol_cmos_split: assert property (@(posedge mclk_i) disable iff (rst_i)
    (fmt_cmos && pol_hi) |-> (drive_o.pol_a_inv == pol_lo && drive_o.pol_b_inv != pol_lo))
    else $error("CMOS halves should have opposite polarity.");

  // ************************************************************
  // Read path checks
  // ************************************************************
  a_read_ctrl: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit_ctrl |=> (rdata_o == $past(ctrl_reg)))
    else $error("Control readback wrong.");
  a_read_status: assert property (@(posedge mclk_i) disable iff (rst_i)
    hit_status |=> (rdata_o == $past(status_byte)))
    else $error("Status readback wrong.");
  a_read_unmapped: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!hit_ctrl && !hit_status) |=> (rdata_o == RD_UNMAPPED_VAL))
    else $error("Unmapped read not zero.");

  // ************************************************************
  // Cover points
  // ************************************************************
  c_cmos_sel: cover property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && hit_ctrl && wdata_i[OC_FORMAT]);
  c_status_rd: cover property (@(posedge mclk_i) disable iff (rst_i)
    hit_status && status_byte[ST_LOCK]);
  c_pdn: cover property (@(posedge mclk_i) disable iff (rst_i) pdn);
  c_b_only: cover property (@(posedge mclk_i) disable iff (rst_i)
    fmt_cmos && cmos_cfg == CMOS_B_ONLY);
  c_status_wr: cover property (@(posedge mclk_i) disable iff (rst_i) wr_i && hit_status);

endmodule

/* File: pll_status_output_ctrl_regs_tb.sv */
`timescale 1ns/1ps
module pll_status_output_ctrl_regs_tb;
  import pso_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] addr_i = 10'h000;
  logic wr_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  pso_monitor_type monitor_i = '0;
  pso_drive_type drive_o;
  int miscompares = 0;
  int total_checks = 0;
  // ****************************************
  // Rows: control byte written, drive struct expected.
  // ****************************************
  logic [15:0] rows [9] = '{16'h8080, 16'hA0C0, 16'hC0A0, 16'hE8F8, 16'hF0E8,
                            16'hF8F0, 16'h066E, 16'h0B13, 16'hE181};

  pso_regs dut (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .monitor_i(monitor_i),
    .drive_o(drive_o)
  );

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Write strobe is left high so back-to-back writes never toggle it in one step.
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    step;
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
    wr_i = 1'b0;
    addr_i = a;
    step;
    chk(what, exp, rdata_o);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    foreach (rows[i]) begin
      wr_reg(ADDR_DRV_CTRL, rows[i][15:8]);
      chk("drive", rows[i][7:0], drive_o);
      rd_chk(ADDR_DRV_CTRL, rows[i][15:8], "control readback");
    end
    $display("test table done");
    for (int b = 0; b < 6; b++) begin
      monitor_i = 6'(1 << b);
      repeat (3) step;
      rd_chk(ADDR_STATUS, 8'(1 << b), "status bit");
    end
    $display("test status bits done");
    monitor_i = 6'h3F;
    repeat (3) step;
    wr_reg(ADDR_STATUS, 8'h00);
    rd_chk(ADDR_STATUS, 8'h3F, "status after write");
    chk("drive after status write", 8'h81, drive_o);
    monitor_i = 6'h00;
    repeat (3) step;
    rd_chk(ADDR_STATUS, 8'h00, "status cleared");
    rd_chk(10'h100, 8'h00, "unmapped read");
    $display("test status write done");
    wr_reg(ADDR_DRV_CTRL, 8'h80);
    wr_reg(ADDR_DRV_CTRL, 8'h0B);
    chk("drive back to back", 8'h13, drive_o);
    rd_chk(ADDR_DRV_CTRL, 8'h0B, "back to back readback");
    $display("test back to back done");
    rst_i = 1'b1;
    step;
    chk("drive in reset", 8'h6A, drive_o);
    chk("read data in reset", 8'h00, rdata_o);
    rst_i = 1'b0;
    rd_chk(ADDR_DRV_CTRL, 8'h62, "control after reset");
    $display("test reset done");
    report_and_stop;
  end
endmodule
